// ===== dv/cap_pwm16_chk.sv
`timescale 1ns/1ps
module cap_pwm16_chk (
   input wire core_clk,
   input wire rst_n,
   input wire count_en,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire module_output_pin,
   input wire irq
);
   reg [15:0] cnt_ff;
   reg [15:0] cmp_ff;
   reg [7:0] mode_ff;
   reg [7:0] cfg_ff;
   wire wide = mode_ff[7] & mode_ff[6] & mode_ff[1];
   wire cw = reg_wr & ~cfg_ff[7];
   // =====================================
   // Mirrors of the counter, compare value, mode and configuration.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
         cmp_ff <= 16'h0000;
         mode_ff <= 8'h00;
         cfg_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + {15'h0000, count_en};
         if (reg_wr && reg_addr == 8'hdf) cfg_ff <= reg_wdata;
         if (reg_wr && reg_addr == 8'hda) mode_ff <= reg_wdata;
         if (cw && reg_addr == 8'hfb) begin
            cmp_ff[7:0] <= reg_wdata;
            mode_ff[6] <= 1'h0;
         end
         if (cw && reg_addr == 8'hfc) begin
            cmp_ff[15:8] <= reg_wdata;
            mode_ff[6] <= 1'h1;
         end
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wrap_low_a: assert property (count_en && cnt_ff == 16'hffff && cmp_ff != 16'h0000
      |=> !module_output_pin) else $error("pin not low after wrap");
   match_high_a: assert property (wide && !reg_wr && count_en &&
      cnt_ff + 16'h0001 == cmp_ff |=> module_output_pin)
      else $error("pin not high after match");
   mode_gate_a: assert property (!wide && !module_output_pin |=> !module_output_pin)
      else $error("pin rose outside wide mode");
   en_clr_a: assert property (reg_rd && reg_addr == 8'hda && !mode_ff[6] |=> !reg_rdata[6])
      else $error("compare enable not cleared");
   en_set_a: assert property (reg_rd && reg_addr == 8'hda && mode_ff[6] |=> reg_rdata[6])
      else $error("compare enable not set");
   unused_zero_a: assert property (reg_rd && reg_addr == 8'hdf |=> reg_rdata[4:2] == 3'h0)
      else $error("unused config bits not zero");
   irq_gate_a: assert property (!cfg_ff[6] && !mode_ff[0] |-> !irq)
      else $error("irq raised while masked");
   evt_irq_a: assert property ($rose(module_output_pin) && mode_ff[3] && mode_ff[0] |-> ##[0:1] irq)
      else $error("no event irq on match");
endmodule // cap_pwm16_chk
bind cap_pwm16 cap_pwm16_chk u_cap_pwm16_chk (.core_clk(core_clk), .rst_n(rst_n),
   .count_en(count_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .module_output_pin(module_output_pin), .irq(irq));

// ===== dv/cap_tb.sv
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic count_en = 1'h1;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   wire [7:0] reg_rdata;
   wire module_output_pin;
   wire irq;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic [7:0] m;
   logic rd_d = 1'h0;
   logic [15:0] cmp;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   always #25 core_clk = ~core_clk;
   cap_pwm16 u_cap_pwm16 (.core_clk(core_clk), .rst_n(rst_n), .count_en(count_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .module_output_pin(module_output_pin), .irq(irq));
   // =====================================
   // Compares a seen value with the expected one and counts both outcomes.
   task chk(input [15:0] seen, input [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One register access; for a read, d and k are the expected value and mask.
   task acc(input w, input [7:0] a, input [7:0] d, input [7:0] k);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(k);
      end
      @(posedge core_clk) #2;
      reg_wr = 0;
      reg_rd = 0;
      @(posedge core_clk) #2;
   endtask
   // Counts clock edges until the pin shows level v, with a bound.
   task wait_pin(input v);
      n = 0;
      while (module_output_pin !== v && n < 70000) begin
         @(posedge core_clk) #2;
         n++;
      end
      if (n >= 70000) mismatches++;
   endtask
   // Read data is settled by the falling edge after it was loaded.
   always @(posedge core_clk) rd_d <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_d) begin
         m = msk_q.pop_front();
         chk({8'h00, reg_rdata & m}, {8'h00, exp_q.pop_front() & m});
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      n = $urandom(32'h16f9_6b9d);
      n = $urandom();
      cmp = {8'h01, n[7:0]};
      repeat (16) @(posedge core_clk);
      #2 rst_n = 1'h1;
      acc(1, 8'hdf, 8'hff, 8'h00);
      acc(0, 8'hdf, 8'he3, 8'hff);
      acc(0, 8'h00, 8'h00, 8'hff);
      acc(1, 8'hda, 8'hcb, 8'h00);
      acc(0, 8'hda, 8'hcb, 8'hff);
      acc(1, 8'hdf, 8'h00, 8'h00);
      acc(1, 8'hfb, cmp[7:0], 8'h00);
      acc(0, 8'hda, 8'h8b, 8'hff);
      acc(1, 8'hdf, 8'h80, 8'h00);
      acc(1, 8'hfc, 8'h55, 8'h00);
      acc(0, 8'hda, 8'h8b, 8'hff);
      acc(0, 8'hfc, 8'h55, 8'hff);
      acc(1, 8'hdf, 8'h00, 8'h00);
      acc(1, 8'hfc, cmp[15:8], 8'h00);
      acc(0, 8'hda, 8'hcb, 8'hff);
      acc(0, 8'hfb, cmp[7:0], 8'hff);
      wait_pin(1);
      wait_pin(0);
      wait_pin(1);
      chk(n[15:0], cmp);
      chk({15'h0000, irq}, 16'h0001);
      acc(0, 8'hd8, 8'h81, 8'h81);
      conclude();
   end
endmodule // tb_top

// ===== hdl/cap_pwm16.v
`timescale 1ns/1ps
`include "cap_regs.vh"
module cap_pwm16 (
   input wire core_clk,
   input wire rst_n,
   input wire count_en,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg module_output_pin,
   output wire irq
);
   // ==========================================
   // Counter, compare and mode state.
   reg [15:0] main_counter_ff;
   reg [15:0] compare_value_ff;
   reg [15:0] reload_ff;
   reg [7:0] module_mode_reg_ff;
   // Configuration fields and event flags.
   reg reload_view_select_ff;
   reg cycle_overflow_irq_enable_ff;
   reg cycle_overflow_flag_ff;
   reg [1:0] cycle_length_select_ff;
   reg counter_overflow_flag_ff;
   reg module_event_flag_ff;
   // Decoded events and write strobes.
   wire [15:0] nxt_main_counter;
   wire wide_mode;
   wire wrap;
   wire match;
   wire event_set;
   wire cyc_ovf;
   wire wr_cfg;
   wire wr_ctrl;
   wire wr_mode;
   wire wr_lo;
   wire wr_hi;

   // Returns one when the low part of the counter is about to roll into the next bit.
   // The selected cycle length sets how many low bits take part.
   function cyc_roll;
      input [15:0] cnt;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: cyc_roll = &cnt[7:0];
            2'b01: cyc_roll = &cnt[8:0];
            2'b10: cyc_roll = &cnt[9:0];
            default: cyc_roll = &cnt[10:0];
         endcase
      end
   endfunction

   // Returns one when the bus address selects the given register.
   function addr_is;
      input [7:0] addr;
      input [7:0] sel_addr;
      begin
         addr_is = (addr == sel_addr);
      end
   endfunction

   // ==========================================
   // Decode of mode and events.
   assign wide_mode = module_mode_reg_ff[`CAP_MODE_CMP_EN] & module_mode_reg_ff[`CAP_MODE_PWM]
      & module_mode_reg_ff[`CAP_MODE_WIDE];
   assign nxt_main_counter = main_counter_ff + 16'h0001;
   assign wrap = count_en & (&main_counter_ff);
   // The pin is a register, so the match looks one count ahead: the pin then stands high
   // while the counter holds the compare value or more, which gives the stated duty.
   assign match = count_en & (nxt_main_counter == compare_value_ff);
   assign event_set = wide_mode & match & module_mode_reg_ff[`CAP_MODE_MATCH];
   assign cyc_ovf = count_en & cyc_roll(main_counter_ff, cycle_length_select_ff);
   // Bus write strobes, one per register.
   assign wr_cfg = reg_wr & addr_is(reg_addr, `CAP_ADDR_CONFIG);
   assign wr_ctrl = reg_wr & addr_is(reg_addr, `CAP_ADDR_CTRL);
   assign wr_mode = reg_wr & addr_is(reg_addr, `CAP_ADDR_MODE);
   assign wr_lo = reg_wr & addr_is(reg_addr, `CAP_ADDR_CMP_LO);
   assign wr_hi = reg_wr & addr_is(reg_addr, `CAP_ADDR_CMP_HI);
   // The shared request is the OR of the cycle overflow and the module event sources.
   assign irq = (cycle_overflow_flag_ff & cycle_overflow_irq_enable_ff)
      | (module_event_flag_ff & module_mode_reg_ff[`CAP_MODE_IRQ_EN]);

   // ==========================================
   // Main counter advances once per counter clock enable. It runs free: the pin and
   // every flag key off this one count.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         main_counter_ff <= 16'h0000;
      end else if (count_en) begin
         main_counter_ff <= nxt_main_counter;
      end
   end

   // ==========================================
   // Configuration register. Bits 4 to 2 have no storage, so a write there is lost
   // and a read returns zero.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reload_view_select_ff <= 1'b0;
         cycle_overflow_irq_enable_ff <= 1'b0;
         cycle_length_select_ff <= 2'b00;
      end else if (wr_cfg) begin
         reload_view_select_ff <= reg_wdata[`CAP_CFG_RELOAD_VIEW];
         cycle_overflow_irq_enable_ff <= reg_wdata[`CAP_CFG_COV_IRQ_EN];
         cycle_length_select_ff <= reg_wdata[1:0];
      end
   end

   // Mode register and compare value. The compare byte writes also move the compare
   // enable, but only in the compare view: the reload bytes share the addresses and
   // carry no side effect.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         compare_value_ff <= 16'h0000;
         module_mode_reg_ff <= 8'h00;
      end else begin
         if (wr_mode) begin
            module_mode_reg_ff <= reg_wdata;
         end
         if (wr_lo & !reload_view_select_ff) begin
            compare_value_ff[7:0] <= reg_wdata;
            module_mode_reg_ff[`CAP_MODE_CMP_EN] <= 1'b0;
         end
         if (wr_hi & !reload_view_select_ff) begin
            compare_value_ff[15:8] <= reg_wdata;
            module_mode_reg_ff[`CAP_MODE_CMP_EN] <= 1'b1;
         end
      end
   end

   // Reload value. It is stored and read back only, since the reload has no use
   // in wide mode.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reload_ff <= 16'h0000;
      end else begin
         if (wr_lo & reload_view_select_ff) begin
            reload_ff[7:0] <= reg_wdata;
         end
         if (wr_hi & reload_view_select_ff) begin
            reload_ff[15:8] <= reg_wdata;
         end
      end
   end

   // ==========================================
   // Flags. A hardware set wins over a software write in the same cycle, so no event
   // is lost. Cycle overflow flag: set on every roll of the selected low counter bits.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         cycle_overflow_flag_ff <= 1'b0;
      end else if (cyc_ovf) begin
         cycle_overflow_flag_ff <= 1'b1;
      end else if (wr_cfg) begin
         cycle_overflow_flag_ff <= reg_wdata[`CAP_CFG_COV_FLAG];
      end
   end

   // Counter overflow flag, set when the main counter wraps, the pin's falling edge.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         counter_overflow_flag_ff <= 1'b0;
      end else if (wrap) begin
         counter_overflow_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         counter_overflow_flag_ff <= reg_wdata[`CAP_CTRL_OVF_FLAG];
      end
   end

   // Module event flag, set on a wide mode match, the pin's rising edge.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         module_event_flag_ff <= 1'b0;
      end else if (event_set) begin
         module_event_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         module_event_flag_ff <= reg_wdata[`CAP_CTRL_EVT_FLAG];
      end
   end

   // ==========================================
   // Output pin: high on match, low on wrap, low whenever wide mode is off. A match
   // wins over a wrap, so a compare value of zero holds the pin high all cycle long.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         module_output_pin <= 1'b0;
      end else if (!wide_mode) begin
         module_output_pin <= 1'b0;
      end else if (match) begin
         module_output_pin <= 1'b1;
      end else if (wrap) begin
         module_output_pin <= 1'b0;
      end
   end

   // ==========================================
   // Read data, registered on a read strobe.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `CAP_ADDR_CONFIG) begin
            reg_rdata <= {reload_view_select_ff, cycle_overflow_irq_enable_ff,
               cycle_overflow_flag_ff, 3'b000, cycle_length_select_ff};
         end else if (reg_addr == `CAP_ADDR_CTRL) begin
            reg_rdata <= {counter_overflow_flag_ff, 6'b00_0000, module_event_flag_ff};
         end else if (reg_addr == `CAP_ADDR_MODE) begin
            reg_rdata <= module_mode_reg_ff;
         end else if (reg_addr == `CAP_ADDR_CMP_LO) begin
            // Compare bytes follow the view select, as the writes do.
            reg_rdata <= reload_view_select_ff ? reload_ff[7:0] : compare_value_ff[7:0];
         end else if (reg_addr == `CAP_ADDR_CMP_HI) begin
            reg_rdata <= reload_view_select_ff ? reload_ff[15:8] : compare_value_ff[15:8];
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule // cap_pwm16

// ===== hdl/cap_regs.vh
// Operation
// - Wide PWM runs apart from 8-11 bit modes; cycle length select ignored.
// - Compare value counts the low time in counter clocks.
// - Output goes high on compare match and low on counter overflow.
// - Wide mode needs compare enable, PWM select and wide select all set.
// - With match flag enable set, every match sets the module event flag.
// - Each 16-bit overflow sets the counter overflow flag.
// - Low byte write clears compare enable; high byte write sets it.
// - Duty equals 65536 minus compare value, over 65536.
// - Compare enable cleared gives zero duty, output stays low.
// - Reload view bit maps compare bytes to reload registers when set.
// - Cycle overflow interrupt enable gates the flag onto the interrupt.
// - Cycle overflow flag sets on bit 8-11 overflow; software clears it.
// - Cycle length select picks 8, 9, 10 or 11 bit cycles.
// - Configuration bits 4 to 2 read zero and ignore writes.
`ifndef CAP_REGS_VH
`define CAP_REGS_VH
// ==========================================
// Register addresses.
`define CAP_ADDR_CONFIG 8'hdf
`define CAP_ADDR_CTRL 8'hd8
`define CAP_ADDR_MODE 8'hda
`define CAP_ADDR_CMP_LO 8'hfb
`define CAP_ADDR_CMP_HI 8'hfc
// ==========================================
// Field positions.
`define CAP_CFG_RELOAD_VIEW 7
`define CAP_CFG_COV_IRQ_EN 6
`define CAP_CFG_COV_FLAG 5
`define CAP_CTRL_OVF_FLAG 7
`define CAP_CTRL_EVT_FLAG 0
`define CAP_MODE_WIDE 7
`define CAP_MODE_CMP_EN 6
`define CAP_MODE_MATCH 3
`define CAP_MODE_PWM 1
`define CAP_MODE_IRQ_EN 0
`define CAP_CONFIG_RESET 8'h00
`endif
